/* File: design/dlt_latency_table.sv */
// dlt_latency_table: read-only ddr latency-code parameter table plus the
// dummy-cycle lookup the read engine uses. byte reads answer one clock later.
// assumes reads come from the query decoder on the same clock.
// How it works
// - byte zero reads parameter identifier 9Ah marking ddr latency table
// - byte one reads length 2Ah; next parameter at offset plus length plus one
// - header row starts with ASCII F then ASCII C
// - fast ddr read codes 0Dh (3-byte) and 0Eh (4-byte)
// - dual ddr read codes BDh (3-byte) and BEh (4-byte)
// - quad ddr read codes EDh (3-byte) and EEh (4-byte)
// - frequency byte is max clock in MHz: 50, then 66 thrice
// - code 11b: fast/dual 0+4, quad 1+3 cycles
// - code 00b: fast 5, dual 6, quad 1+6 cycles
// - code 01b: fast 6, dual 7, quad 1+7 cycles
// - code 10b: fast 7, dual 8, quad 1 mode cycle
`default_nettype none
module dlt_latency_table (
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      rd_en_in,
    input  wire logic [dlt_pkg::DLT_AW-1:0] rd_addr_in,
    input  wire logic [1:0]                lat_code_in,
    input  wire logic [1:0]                rd_kind_in,
    output logic      [dlt_pkg::DLT_DW-1:0] rd_data_out,
    output logic                           rd_valid_out,
    output logic      [7:0]                mode_cycles_out,
    output logic      [7:0]                lat_cycles_out
);
    import dlt_pkg::*;

    // ==========================================================
    // table contents
    function automatic logic [7:0] table_byte(input logic [5:0] a);
        logic [7:0] d;
        d = DLT_OOR_DATA;
        case (a)
            DLT_OFS_ID:    d = DLT_PARAM_ID;
            DLT_OFS_LEN:   d = DLT_PARAM_LEN;
            DLT_OFS_ROWS:  d = DLT_NUM_ROWS;
            DLT_OFS_RLEN:  d = DLT_ROW_LEN;
            DLT_OFS_HDR_F: d = DLT_ASCII_F;
            DLT_OFS_HDR_C: d = DLT_ASCII_C;
            DLT_OFS_FAST3: d = DLT_FAST_3B;
            DLT_OFS_FAST4: d = DLT_FAST_4B;
            DLT_OFS_DUAL3: d = DLT_DUAL_3B;
            DLT_OFS_DUAL4: d = DLT_DUAL_4B;
            DLT_OFS_QUAD3: d = DLT_QUAD_3B;
            DLT_OFS_QUAD4: d = DLT_QUAD_4B;
            DLT_OFS_ROW2 + DLT_FLD_FREQ: d = DLT_MHZ_50;
            DLT_OFS_ROW3 + DLT_FLD_FREQ,
            DLT_OFS_ROW4 + DLT_FLD_FREQ,
            DLT_OFS_ROW5 + DLT_FLD_FREQ: d = DLT_MHZ_66;
            DLT_OFS_ROW2 + DLT_FLD_CODE: d = {6'h00, DLT_LC_11};
            DLT_OFS_ROW2 + DLT_FLD_FM,
            DLT_OFS_ROW2 + DLT_FLD_DM:   d = DLT_M0;
            DLT_OFS_ROW2 + DLT_FLD_FL,
            DLT_OFS_ROW2 + DLT_FLD_DL:   d = DLT_L4;
            DLT_OFS_ROW2 + DLT_FLD_QM:   d = DLT_M1;
            DLT_OFS_ROW2 + DLT_FLD_QL:   d = DLT_L3;
            DLT_OFS_ROW3 + DLT_FLD_CODE: d = {6'h00, DLT_LC_00};
            DLT_OFS_ROW3 + DLT_FLD_FM,
            DLT_OFS_ROW3 + DLT_FLD_DM:   d = DLT_M0;
            DLT_OFS_ROW3 + DLT_FLD_FL:   d = DLT_L5;
            DLT_OFS_ROW3 + DLT_FLD_DL,
            DLT_OFS_ROW3 + DLT_FLD_QL:   d = DLT_L6;
            DLT_OFS_ROW3 + DLT_FLD_QM:   d = DLT_M1;
            DLT_OFS_ROW4 + DLT_FLD_CODE: d = {6'h00, DLT_LC_01};
            DLT_OFS_ROW4 + DLT_FLD_FM,
            DLT_OFS_ROW4 + DLT_FLD_DM:   d = DLT_M0;
            DLT_OFS_ROW4 + DLT_FLD_FL:   d = DLT_L6;
            DLT_OFS_ROW4 + DLT_FLD_DL,
            DLT_OFS_ROW4 + DLT_FLD_QL:   d = DLT_L7;
            DLT_OFS_ROW4 + DLT_FLD_QM:   d = DLT_M1;
            // code 10b row; last latency byte is truncated
            DLT_OFS_ROW5 + DLT_FLD_CODE: d = {6'h00, DLT_LC_10};
            DLT_OFS_ROW5 + DLT_FLD_FM,
            DLT_OFS_ROW5 + DLT_FLD_DM:   d = DLT_M0;
            DLT_OFS_ROW5 + DLT_FLD_FL:   d = DLT_L7;
            DLT_OFS_ROW5 + DLT_FLD_DL:   d = DLT_L8;
            DLT_OFS_ROW5 + DLT_FLD_QM:   d = DLT_M1;
            default: d = DLT_OOR_DATA;
        endcase
        return d;
    endfunction

    // ==========================================================
    // byte read port
    logic [7:0] next_rd_data;
    logic       next_rd_valid;
    logic [7:0] next_mode;
    logic [7:0] next_lat;
    logic [5:0] row_base;

    always_comb begin
        next_rd_valid = rd_en_in;
        next_rd_data  = rd_en_in ? table_byte(rd_addr_in) : rd_data_out;
        // row start: code 11b is row 2, 00b row 3, 01b row 4, 10b row 5
        case (lat_code_in)
            DLT_LC_11: row_base = DLT_OFS_ROW2;
            DLT_LC_00: row_base = DLT_OFS_ROW3;
            DLT_LC_01: row_base = DLT_OFS_ROW4;
            default:   row_base = DLT_OFS_ROW5;
        endcase
        // dummy lookup from the same table
        case (rd_kind_in)
            DLT_RD_FAST: begin
                next_mode = table_byte(row_base + DLT_FLD_FM);
                next_lat  = table_byte(row_base + DLT_FLD_FL);
            end
            DLT_RD_DUAL: begin
                next_mode = table_byte(row_base + DLT_FLD_DM);
                next_lat  = table_byte(row_base + DLT_FLD_DL);
            end
            default: begin
                next_mode = table_byte(row_base + DLT_FLD_QM);
                next_lat  = table_byte(row_base + DLT_FLD_QL);
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_data_out     <= 8'h00;
            rd_valid_out    <= 1'b0;
            mode_cycles_out <= 8'h00;
            lat_cycles_out  <= 8'h00;
        end else begin
            rd_data_out     <= next_rd_data;
            rd_valid_out    <= next_rd_valid;
            mode_cycles_out <= next_mode;
            lat_cycles_out  <= next_lat;
        end
    end

    // ==========================================================
    // checks
    // reset is synchronous, so the release edge still clears the outputs;
    // the disable alone misses that attempt, hence reset low in each antecedent
    AST_ID_BYTE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_ID
        |=> rd_valid_out && rd_data_out == DLT_PARAM_ID)
        else $error("id byte wrong");
    AST_LEN_BYTE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_LEN
        |=> rd_data_out == DLT_PARAM_LEN)
        else $error("length byte wrong");
    // past the block every offset reads the unsupported marker
    AST_OOR_BYTE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in > DLT_LAST_OFS
        |=> rd_valid_out && rd_data_out == DLT_OOR_DATA)
        else $error("byte beyond block wrong");
    AST_HDR_F: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_HDR_F
        |=> rd_data_out == DLT_ASCII_F)
        else $error("header F wrong");
    AST_HDR_C: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_HDR_C
        |=> rd_data_out == DLT_ASCII_C)
        else $error("header C wrong");
    AST_FAST3_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_FAST3
        |=> rd_data_out == DLT_FAST_3B)
        else $error("fast 3-byte code wrong");
    AST_FAST_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_FAST4
        |=> rd_data_out == DLT_FAST_4B)
        else $error("fast 4-byte code wrong");
    AST_DUAL_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_DUAL3
        |=> rd_data_out == DLT_DUAL_3B)
        else $error("dual 3-byte code wrong");
    AST_DUAL4_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_DUAL4
        |=> rd_data_out == DLT_DUAL_4B)
        else $error("dual 4-byte code wrong");
    AST_QUAD3_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_QUAD3
        |=> rd_data_out == DLT_QUAD_3B)
        else $error("quad 3-byte code wrong");
    AST_QUAD_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_QUAD4
        |=> rd_data_out == DLT_QUAD_4B)
        else $error("quad 4-byte code wrong");
    AST_FREQ_50: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_ROW2 + DLT_FLD_FREQ
        |=> rd_data_out == DLT_MHZ_50)
        else $error("row 2 frequency wrong");
    AST_FREQ_66: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && (rd_addr_in == DLT_OFS_ROW3 + DLT_FLD_FREQ
        || rd_addr_in == DLT_OFS_ROW4 + DLT_FLD_FREQ
        || rd_addr_in == DLT_OFS_ROW5 + DLT_FLD_FREQ)
        |=> rd_data_out == DLT_MHZ_66)
        else $error("rows 3 to 5 frequency wrong");
    AST_LC11_FAST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_11 && rd_kind_in == DLT_RD_FAST
        |=> mode_cycles_out == DLT_M0 && lat_cycles_out == DLT_L4)
        else $error("code 11b fast dummy wrong");
    AST_LC11_QUAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_11 && rd_kind_in == DLT_RD_QUAD
        |=> mode_cycles_out == DLT_M1 && lat_cycles_out == DLT_L3)
        else $error("code 11b quad dummy wrong");
    AST_LC00_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && rd_en_in && rd_addr_in == DLT_OFS_ROW3 + DLT_FLD_CODE
        |=> rd_data_out == {6'h00, DLT_LC_00})
        else $error("row 3 code byte wrong");
    AST_LC00_DUAL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_00 && rd_kind_in == DLT_RD_DUAL
        |=> mode_cycles_out == DLT_M0 && lat_cycles_out == DLT_L6)
        else $error("code 00b dual dummy wrong");
    AST_LC00_QUAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_00 && rd_kind_in == DLT_RD_QUAD
        |=> mode_cycles_out == DLT_M1 && lat_cycles_out == DLT_L6)
        else $error("code 00b quad dummy wrong");
    AST_LC01_FAST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_01 && rd_kind_in == DLT_RD_FAST
        |=> mode_cycles_out == DLT_M0 && lat_cycles_out == DLT_L6)
        else $error("code 01b fast dummy wrong");
    AST_LC01_QUAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_01 && rd_kind_in == DLT_RD_QUAD
        |=> mode_cycles_out == DLT_M1 && lat_cycles_out == DLT_L7)
        else $error("code 01b quad dummy wrong");
    AST_LC10_DUAL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_10 && rd_kind_in == DLT_RD_DUAL
        |=> mode_cycles_out == DLT_M0 && lat_cycles_out == DLT_L8)
        else $error("code 10b dual dummy wrong");
    // quad latency of this row is absent, so it reads the unsupported marker
    AST_LC10_QUAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sys_rst_in && lat_code_in == DLT_LC_10 && rd_kind_in == DLT_RD_QUAD
        |=> mode_cycles_out == DLT_M1 && lat_cycles_out == DLT_OOR_DATA)
        else $error("code 10b quad dummy wrong");
endmodule
`default_nettype wire

/* File: design/dlt_pkg.sv */
// dlt_pkg: constants for the ddr latency-code parameter table.
// assumes a single 10 MHz clock domain; shared by the table module and the bench.
package dlt_pkg;
    localparam int unsigned DLT_AW        = 6;
    localparam int unsigned DLT_DW        = 8;
    localparam logic [5:0]  DLT_LAST_OFS  = 6'h2a;
    localparam logic [7:0]  DLT_OOR_DATA  = 8'hff;
    localparam logic [7:0]  DLT_PARAM_ID  = 8'h9a;
    localparam logic [7:0]  DLT_PARAM_LEN = 8'h2a;
    localparam logic [7:0]  DLT_NUM_ROWS  = 8'h05;
    localparam logic [7:0]  DLT_ROW_LEN   = 8'h08;
    localparam logic [7:0]  DLT_ASCII_F   = 8'h46;
    localparam logic [7:0]  DLT_ASCII_C   = 8'h43;
    localparam logic [7:0]  DLT_FAST_3B   = 8'h0d;
    localparam logic [7:0]  DLT_FAST_4B   = 8'h0e;
    localparam logic [7:0]  DLT_DUAL_3B   = 8'hbd;
    localparam logic [7:0]  DLT_DUAL_4B   = 8'hbe;
    localparam logic [7:0]  DLT_QUAD_3B   = 8'hed;
    localparam logic [7:0]  DLT_QUAD_4B   = 8'hee;
    localparam logic [7:0]  DLT_MHZ_50    = 8'h32;
    localparam logic [7:0]  DLT_MHZ_66    = 8'h42;
    localparam logic [1:0]  DLT_LC_00     = 2'h0;
    localparam logic [1:0]  DLT_LC_01     = 2'h1;
    localparam logic [1:0]  DLT_LC_10     = 2'h2;
    localparam logic [1:0]  DLT_LC_11     = 2'h3;
    // byte offsets inside the parameter block
    localparam logic [5:0]  DLT_OFS_ID    = 6'h00;
    localparam logic [5:0]  DLT_OFS_LEN   = 6'h01;
    localparam logic [5:0]  DLT_OFS_ROWS  = 6'h02;
    localparam logic [5:0]  DLT_OFS_RLEN  = 6'h03;
    localparam logic [5:0]  DLT_OFS_HDR_F = 6'h04;
    localparam logic [5:0]  DLT_OFS_HDR_C = 6'h05;
    localparam logic [5:0]  DLT_OFS_FAST3 = 6'h06;
    localparam logic [5:0]  DLT_OFS_FAST4 = 6'h07;
    localparam logic [5:0]  DLT_OFS_DUAL3 = 6'h08;
    localparam logic [5:0]  DLT_OFS_DUAL4 = 6'h09;
    localparam logic [5:0]  DLT_OFS_QUAD3 = 6'h0a;
    localparam logic [5:0]  DLT_OFS_QUAD4 = 6'h0b;
    // each latency row: frequency, code, then mode/latency for fast, dual, quad
    localparam logic [5:0]  DLT_OFS_ROW2  = 6'h0c;
    localparam logic [5:0]  DLT_OFS_ROW3  = 6'h14;
    localparam logic [5:0]  DLT_OFS_ROW4  = 6'h1c;
    localparam logic [5:0]  DLT_OFS_ROW5  = 6'h24;
    localparam logic [5:0]  DLT_FLD_FREQ  = 6'h00;
    localparam logic [5:0]  DLT_FLD_CODE  = 6'h01;
    localparam logic [5:0]  DLT_FLD_FM    = 6'h02;
    localparam logic [5:0]  DLT_FLD_FL    = 6'h03;
    localparam logic [5:0]  DLT_FLD_DM    = 6'h04;
    localparam logic [5:0]  DLT_FLD_DL    = 6'h05;
    localparam logic [5:0]  DLT_FLD_QM    = 6'h06;
    localparam logic [5:0]  DLT_FLD_QL    = 6'h07;
    // dummy settings per latency code: mode/latency for fast, dual, quad
    localparam logic [7:0]  DLT_M0        = 8'h00;
    localparam logic [7:0]  DLT_M1        = 8'h01;
    localparam logic [7:0]  DLT_L3        = 8'h03;
    localparam logic [7:0]  DLT_L4        = 8'h04;
    localparam logic [7:0]  DLT_L5        = 8'h05;
    localparam logic [7:0]  DLT_L6        = 8'h06;
    localparam logic [7:0]  DLT_L7        = 8'h07;
    localparam logic [7:0]  DLT_L8        = 8'h08;
    typedef enum logic [1:0] {
        DLT_RD_FAST = 2'h0,
        DLT_RD_DUAL = 2'h1,
        DLT_RD_QUAD = 2'h3
    } dlt_rd_kind_t;
endpackage

/* File: dv/dlt_host_model.sv */
// dlt_host_model: host side that adds mode and latency into one dummy count.
// assumes lookup outputs are registered on the same clock.
`default_nettype none
module dlt_host_model (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [7:0] mode_cycles_in,
    input  wire logic [7:0] lat_cycles_in,
    output logic      [7:0] dummy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // dummy cycle total
    // ffh means unsupported and wraps; a real host tests for it first
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) dummy_out <= 8'h00;
        else dummy_out <= mode_cycles_in + lat_cycles_in;
    end
endmodule
`default_nettype wire

/* File: dv/dlt_latency_table_bench.sv */
// dlt_latency_table_bench: sweeps every offset and every lookup back to back.
// assumes answers one clock after each request.
`default_nettype none
module dlt_latency_table_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dlt_pkg::*;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       rd_en_in = 1'b0;
    logic [5:0] rd_addr_in = 6'h00;
    logic [1:0] lat_code_in = 2'h0;
    logic [1:0] rd_kind_in = 2'h0;
    logic [7:0] rd_data_out, mode_cycles_out, lat_cycles_out, dummy;
    logic       rd_valid_out;
    int         n_fail = 0;
    int         checked = 0;
    int         cyc = 0;
    // rows: offset -> byte; offsets 2bh and up read ffh
    logic [7:0] tbl [0:42] = '{8'h9a,8'h2a,8'h05,8'h08,8'h46,8'h43,8'h0d,8'h0e,8'hbd,8'hbe,
        8'hed,8'hee,8'h32,8'h03,8'h00,8'h04,8'h00,8'h04,8'h01,8'h03,8'h42,8'h00,8'h00,8'h05,
        8'h00,8'h06,8'h01,8'h06,8'h42,8'h01,8'h00,8'h06,8'h00,8'h07,8'h01,8'h07,8'h42,8'h02,
        8'h00,8'h07,8'h00,8'h08,8'h01};
    // rows: {code, kind} -> {mode, latency}; kind 2 acts as quad
    logic [15:0] lut [0:15] = '{16'h0005,16'h0006,16'h0106,16'h0106,16'h0006,16'h0007,
        16'h0107,16'h0107,16'h0007,16'h0008,16'h01ff,16'h01ff,16'h0004,16'h0004,16'h0103,16'h0103};

    dlt_latency_table u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rd_en_in(rd_en_in),
        .rd_addr_in(rd_addr_in), .lat_code_in(lat_code_in), .rd_kind_in(rd_kind_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .mode_cycles_out(mode_cycles_out), .lat_cycles_out(lat_cycles_out));
    dlt_host_model u_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .mode_cycles_in(mode_cycles_out), .lat_cycles_in(lat_cycles_out), .dummy_out(dummy));

    initial forever #50 clk_in = ~clk_in;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang never gets past this ceiling
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 500) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i <= 64; i++) begin
            @(posedge clk_in);
            rd_en_in    <= (i < 64);
            rd_addr_in  <= i[5:0];
            lat_code_in <= i[3:2];
            rd_kind_in  <= i[1:0];
            @(negedge clk_in);
            if (i > 0) begin
                check("valid", {7'h00, rd_valid_out}, 8'h01);
                check("byte", rd_data_out, (i < 44) ? tbl[i-1] : 8'hff);
                check("mode", mode_cycles_out, lut[(i-1)%16][15:8]);
                check("lat", lat_cycles_out, lut[(i-1)%16][7:0]);
            end
            if (i > 1) check("dummy", dummy, lut[(i-2)%16][15:8] + lut[(i-2)%16][7:0]);
        end
        @(negedge clk_in);
        check("valid drop", {7'h00, rd_valid_out}, 8'h00);
        check("byte hold", rd_data_out, 8'hff);
        $display("sweep test done");
        @(posedge clk_in);
        rd_en_in   <= 1'b1;
        sys_rst_in <= 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        check("rst valid", {7'h00, rd_valid_out}, 8'h00);
        check("rst byte", rd_data_out, 8'h00);
        check("rst mode", mode_cycles_out, 8'h00);
        check("rst lat", lat_cycles_out, 8'h00);
        $display("reset test done");
        // release with the request already up: first read lands one edge later
        @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd_addr_in <= 6'h01;
        @(posedge clk_in);
        @(negedge clk_in);
        check("rel valid", {7'h00, rd_valid_out}, 8'h01);
        check("rel byte", rd_data_out, 8'h2a);
        check("rel mode", mode_cycles_out, 8'h00);
        check("rel lat", lat_cycles_out, 8'h05);
        $display("release test done");
        end_of_test();
    end
endmodule
`default_nettype wire
